// ---- rtl/spcmd_cfg.svh ----
// offsets, field positions, reset values and presets of the port id/command registers
`ifndef SPCMD_CFG_SVH
`define SPCMD_CFG_SVH

// =====================================================
// register offsets (byte addresses of config dwords)
`define SPCMD_OFF_ID 12'h000
`define SPCMD_OFF_CMD 12'h004

// =====================================================
// identification presets (arbitrary values, not a real maker or part)
`define SPCMD_MAKER_PRESET 16'hA5C3
`define SPCMD_PART_PRESET 16'h3C5A

// =====================================================
// command register field positions
`define SPCMD_BIT_IO_EN 0
`define SPCMD_BIT_MEM_EN 1
`define SPCMD_BIT_FWD_EN 2
`define SPCMD_BIT_PARITY_EN 6
`define SPCMD_BIT_ERR_REPORT 8
`define SPCMD_BIT_INTX_OFF 10

// writable bits: 0,1,2,6,8,10; legacy bits 3,4,5,7,9 and reserved 15:11 stay zero
`define SPCMD_CMD_RW_MASK 16'h0547
`define SPCMD_CMD_RESERVED_PRESERVE 16'hF800
`define SPCMD_CMD_RESET 16'h0000

// =====================================================
// a zero half word and a zero dword
`define SPCMD_HALF_ZERO 16'h0000
`define SPCMD_DWORD_ZERO 32'h00000000

`endif

// ---- rtl/spcmd_pkg.sv ----
// types and helper functions of the port id/command registers
package spcmd_pkg;

   typedef logic [15:0] spcmd_half_t;
   typedef logic [31:0] spcmd_dword_t;

   typedef enum logic [1:0] {
      spcmd_acc_none,
      spcmd_acc_read,
      spcmd_acc_write
   } spcmd_acc_t;

   // merge two write bytes into a 16-bit field under byte enables and a write mask
   function automatic spcmd_half_t be_merge16(input spcmd_half_t old_v,
                                              input spcmd_half_t new_v,
                                              input logic [1:0] be,
                                              input spcmd_half_t wmask);
      spcmd_half_t lane;
      lane = {{8{be[1]}}, {8{be[0]}}} & wmask;
      return (old_v & ~lane) | (new_v & lane);
   endfunction

   // dword index match of a byte address against an offset
   function automatic logic dw_hit(input logic [11:0] addr, input logic [11:0] off);
      return addr[11:2] == off[11:2];
   endfunction

endpackage

// ---- rtl/spcmd_id_store.sv ----
// holder of the loadable maker and part identification codes
`timescale 1ns/1ns
`include "spcmd_cfg.svh"

module spcmd_id_store #(
   parameter logic [15:0] MAKER_PRESET = `SPCMD_MAKER_PRESET,
   parameter logic [15:0] PART_PRESET = `SPCMD_PART_PRESET
) (
   // clock and reset
   input wire logic core_clk,
   input wire logic srst,
   // loads from eeprom or sideband bus
   input wire logic maker_load_valid,
   input wire spcmd_pkg::spcmd_half_t maker_load_data,
   input wire logic part_load_valid,
   input wire spcmd_pkg::spcmd_half_t part_load_data,
   // current codes
   output spcmd_pkg::spcmd_half_t maker_q,
   output spcmd_pkg::spcmd_half_t part_q
);

   spcmd_pkg::spcmd_half_t maker_r;
   spcmd_pkg::spcmd_half_t part_r;

   // =====================================================
   // code registers
   // maker preset or load
   always_ff @(posedge core_clk) begin
      if (srst) begin
         maker_r <= MAKER_PRESET;
         part_r <= PART_PRESET;
      end else begin
         if (maker_load_valid) begin
            maker_r <= maker_load_data;
         end
         if (part_load_valid) begin
            part_r <= part_load_data;
         end
      end
   end

   assign maker_q = maker_r;
   assign part_q = part_r;

endmodule // spcmd_id_store

// ---- rtl/spcmd_regs.sv ----
// identification and command registers of a switch port, with the command gating
`timescale 1ns/1ns
`include "spcmd_cfg.svh"

module spcmd_regs (
   // clock and reset
   input wire logic core_clk,
   input wire logic srst,
   // configuration requests from the link
   input wire logic cfg_req_valid,
   input wire logic cfg_req_write,
   input wire logic [11:0] cfg_req_addr,
   input wire logic [3:0] cfg_req_be,
   input wire spcmd_pkg::spcmd_dword_t cfg_req_wdata,
   // configuration completions
   output logic cfg_cpl_valid,
   output spcmd_pkg::spcmd_dword_t cfg_cpl_rdata,
   // identification loads
   input wire logic maker_load_valid,
   input wire spcmd_pkg::spcmd_half_t maker_load_data,
   input wire logic part_load_valid,
   input wire spcmd_pkg::spcmd_half_t part_load_data,
   // primary side requests
   input wire logic pri_req_valid,
   input wire logic pri_req_io,
   input wire logic pri_req_mem,
   output logic pri_req_take,
   output logic pri_req_ignore,
   // downstream side requests bound upstream
   input wire logic dsr_req_valid,
   input wire logic dsr_req_memio,
   input wire logic dsr_req_np,
   output logic up_fwd,
   output logic ur_cpl,
   // errors
   input wire logic parity_err_det,
   input wire logic err_fatal_det,
   input wire logic err_nonfatal_det,
   output logic parity_handle,
   output logic err_fatal_msg,
   output logic err_nonfatal_msg,
   // interrupts
   input wire logic own_intx_req,
   input wire logic fwd_intx_req,
   output logic intx_own_msg,
   output logic intx_fwd_msg,
   // command view
   output spcmd_pkg::spcmd_half_t cmd_view
);

   // =====================================================
   // declarations
   spcmd_pkg::spcmd_half_t maker_q;
   spcmd_pkg::spcmd_half_t part_q;
   spcmd_pkg::spcmd_half_t cmd_r;
   spcmd_pkg::spcmd_half_t cmd_nxt;
   spcmd_pkg::spcmd_half_t cmd_view_r;
   spcmd_pkg::spcmd_acc_t acc;
   spcmd_pkg::spcmd_dword_t rdata_nxt;
   spcmd_pkg::spcmd_dword_t cpl_rdata_r;
   logic cpl_valid_r;
   logic hit_id;
   logic hit_cmd;
   logic io_en;
   logic mem_en;
   logic fwd_en;
   logic parity_en;
   logic err_report;
   logic intx_off;
   logic pri_take_nxt;
   logic pri_take_r;
   logic pri_ignore_r;
   logic up_fwd_r;
   logic ur_cpl_r;
   logic parity_handle_r;
   logic err_fatal_r;
   logic err_nonfatal_r;
   logic intx_own_r;
   logic intx_fwd_r;

   // =====================================================
   // identification store
   spcmd_id_store u_id_store (
      .core_clk(core_clk),
      .srst(srst),
      .maker_load_valid(maker_load_valid),
      .maker_load_data(maker_load_data),
      .part_load_valid(part_load_valid),
      .part_load_data(part_load_data),
      .maker_q(maker_q),
      .part_q(part_q)
   );

   // =====================================================
   // request decode
   assign hit_id = spcmd_pkg::dw_hit(cfg_req_addr, `SPCMD_OFF_ID);
   assign hit_cmd = spcmd_pkg::dw_hit(cfg_req_addr, `SPCMD_OFF_CMD);
   assign acc = !cfg_req_valid ? spcmd_pkg::spcmd_acc_none :
                cfg_req_write ? spcmd_pkg::spcmd_acc_write : spcmd_pkg::spcmd_acc_read;

   assign cmd_nxt = (acc == spcmd_pkg::spcmd_acc_write && hit_cmd) ?
                    spcmd_pkg::be_merge16(cmd_r, cfg_req_wdata[15:0], cfg_req_be[1:0],
                                          `SPCMD_CMD_RW_MASK & ~`SPCMD_CMD_RESERVED_PRESERVE) :
                    cmd_r;

   // part code high half
   // status half and unmapped dwords read zero
   assign rdata_nxt = (acc != spcmd_pkg::spcmd_acc_read) ? `SPCMD_DWORD_ZERO :
                      hit_id ? {part_q, maker_q} :
                      hit_cmd ? {`SPCMD_HALF_ZERO, cmd_r} : `SPCMD_DWORD_ZERO;

   // =====================================================
   // command fields
   assign io_en = cmd_r[`SPCMD_BIT_IO_EN];
   assign mem_en = cmd_r[`SPCMD_BIT_MEM_EN];
   assign fwd_en = cmd_r[`SPCMD_BIT_FWD_EN];
   assign parity_en = cmd_r[`SPCMD_BIT_PARITY_EN];
   assign err_report = cmd_r[`SPCMD_BIT_ERR_REPORT];
   assign intx_off = cmd_r[`SPCMD_BIT_INTX_OFF];

   assign pri_take_nxt = pri_req_valid && ((pri_req_io && io_en) || (pri_req_mem && mem_en));

   // =====================================================
   // register file and completion
   // command resets to zero
   always_ff @(posedge core_clk) begin
      if (srst) begin
         cmd_r <= `SPCMD_CMD_RESET;
         cmd_view_r <= `SPCMD_CMD_RESET;
         cpl_valid_r <= 1'b0;
         cpl_rdata_r <= `SPCMD_DWORD_ZERO;
      end else begin
         cmd_r <= cmd_nxt;
         cmd_view_r <= cmd_r;
         cpl_valid_r <= (acc != spcmd_pkg::spcmd_acc_none);
         cpl_rdata_r <= rdata_nxt;
      end
   end

   // =====================================================
   // primary side gating
   always_ff @(posedge core_clk) begin
      if (srst) begin
         pri_take_r <= 1'b0;
         pri_ignore_r <= 1'b0;
      end else begin
         pri_take_r <= pri_take_nxt;
         pri_ignore_r <= pri_req_valid && !pri_take_nxt;
      end
   end

   // =====================================================
   // upstream forwarding
   // blocked when bit 2 clear
   always_ff @(posedge core_clk) begin
      if (srst) begin
         up_fwd_r <= 1'b0;
         ur_cpl_r <= 1'b0;
      end else begin
         up_fwd_r <= dsr_req_valid && dsr_req_memio && fwd_en;
         ur_cpl_r <= dsr_req_valid && dsr_req_memio && dsr_req_np && !fwd_en;
      end
   end

   // =====================================================
   // error and own interrupt gating; forwarded interrupts pass ungated
   // parity response gate
   always_ff @(posedge core_clk) begin
      if (srst) begin
         parity_handle_r <= 1'b0;
         err_fatal_r <= 1'b0;
         err_nonfatal_r <= 1'b0;
         intx_own_r <= 1'b0;
         intx_fwd_r <= 1'b0;
      end else begin
         parity_handle_r <= parity_err_det && parity_en;
         err_fatal_r <= err_fatal_det && err_report;
         err_nonfatal_r <= err_nonfatal_det && err_report;
         intx_own_r <= own_intx_req && !intx_off;
         intx_fwd_r <= fwd_intx_req;
      end
   end

   // =====================================================
   // outputs
   assign cfg_cpl_valid = cpl_valid_r;
   assign cfg_cpl_rdata = cpl_rdata_r;
   assign pri_req_take = pri_take_r;
   assign pri_req_ignore = pri_ignore_r;
   assign up_fwd = up_fwd_r;
   assign ur_cpl = ur_cpl_r;
   assign parity_handle = parity_handle_r;
   assign err_fatal_msg = err_fatal_r;
   assign err_nonfatal_msg = err_nonfatal_r;
   assign intx_own_msg = intx_own_r;
   assign intx_fwd_msg = intx_fwd_r;
   assign cmd_view = cmd_view_r;

   // =====================================================
   // assertions
   default clocking cb @(posedge core_clk);
   endclocking
   default disable iff (srst);

   property p_maker_read;
      (cfg_req_valid && !cfg_req_write && hit_id) |=> cfg_cpl_rdata[15:0] == $past(maker_q);
   endproperty
   a_maker_read: assert property (p_maker_read)
      else $error("maker code read mismatch");

   property p_part_read;
      (cfg_req_valid && !cfg_req_write && hit_id) |=> cfg_cpl_rdata[31:16] == $past(part_q);
   endproperty
   a_part_read: assert property (p_part_read)
      else $error("part code read mismatch");

   property p_id_write_ignored;
      (cfg_req_valid && cfg_req_write && hit_id && !maker_load_valid && !part_load_valid)
         |=> (maker_q == $past(maker_q)) && (part_q == $past(part_q));
   endproperty
   a_id_write_ignored: assert property (p_id_write_ignored)
      else $error("id code changed by config write");

   property p_io_ignore;
      (pri_req_valid && pri_req_io && !pri_req_mem && !io_en) |=> pri_req_ignore && !pri_req_take;
   endproperty
   a_io_ignore: assert property (p_io_ignore)
      else $error("io request taken while io decode off");

   property p_mem_take;
      (pri_req_valid && pri_req_mem && mem_en) |=> pri_req_take && !pri_req_ignore;
   endproperty
   a_mem_take: assert property (p_mem_take)
      else $error("memory request not taken while enabled");

   property p_fwd_block;
      (dsr_req_valid && dsr_req_memio && !fwd_en) |=> !up_fwd && (ur_cpl == $past(dsr_req_np));
   endproperty
   a_fwd_block: assert property (p_fwd_block)
      else $error("upstream forward while forwarding off");

   property p_ur_only_np;
      ur_cpl |-> $past(dsr_req_np) && !$past(fwd_en);
   endproperty
   a_ur_only_np: assert property (p_ur_only_np)
      else $error("ur completion without rejected non-posted request");

   property p_fwd_pass;
      (dsr_req_valid && dsr_req_memio && fwd_en) |=> up_fwd && !ur_cpl;
   endproperty
   a_fwd_pass: assert property (p_fwd_pass)
      else $error("request not forwarded upstream");

   property p_parity_gate;
      parity_handle |-> $past(parity_err_det) && $past(parity_en);
   endproperty
   a_parity_gate: assert property (p_parity_gate)
      else $error("parity handled while response disabled");

   property p_err_gate;
      (err_fatal_det || err_nonfatal_det) |=>
         (err_fatal_msg == ($past(err_fatal_det) && $past(err_report))) &&
         (err_nonfatal_msg == ($past(err_nonfatal_det) && $past(err_report)));
   endproperty
   a_err_gate: assert property (p_err_gate)
      else $error("error report not gated by enable");

   property p_intx_gate;
      (own_intx_req && intx_off) ##1 1'b1 |-> !intx_own_msg;
   endproperty
   a_intx_gate: assert property (p_intx_gate)
      else $error("own intx sent while disabled");

   property p_intx_fwd;
      fwd_intx_req |=> intx_fwd_msg;
   endproperty
   a_intx_fwd: assert property (p_intx_fwd)
      else $error("forwarded intx blocked");

   property p_legacy_zero;
      (cfg_req_valid && cfg_req_write && hit_cmd) |->
         ##2 (cmd_view & ~`SPCMD_CMD_RW_MASK) == `SPCMD_HALF_ZERO;
   endproperty
   a_legacy_zero: assert property (p_legacy_zero)
      else $error("legacy command bit not zero");

   property p_reserved_zero;
      cfg_cpl_valid |-> (cmd_r & `SPCMD_CMD_RESERVED_PRESERVE) == `SPCMD_HALF_ZERO;
   endproperty
   a_reserved_zero: assert property (p_reserved_zero)
      else $error("reserved command bits changed");

   c_cmd_write: cover property (cfg_req_valid && cfg_req_write && hit_cmd && cfg_req_be[0]);
   c_ur_np: cover property (ur_cpl);
   c_fwd: cover property (up_fwd);
   c_id_load_read: cover property (maker_load_valid ##1 (cfg_req_valid && hit_id));

endmodule // spcmd_regs

// ---- test/spcmd_root_model.sv ----
// root complex model issuing configuration requests to the port
`timescale 1ns/1ns
module spcmd_root_model (
   // clock
   input wire logic core_clk,
   // requests
   output logic cfg_req_valid,
   output logic cfg_req_write,
   output logic [11:0] cfg_req_addr,
   output logic [3:0] cfg_req_be,
   output spcmd_pkg::spcmd_dword_t cfg_req_wdata,
   // completions
   input wire logic cfg_cpl_valid,
   input wire spcmd_pkg::spcmd_dword_t cfg_cpl_rdata
);
   initial begin
      cfg_req_valid = 1'b0;
      cfg_req_write = 1'b0;
      cfg_req_addr = 12'hFFF;
      cfg_req_be = 4'h0;
      cfg_req_wdata = 32'h00000000;
   end
   // one request gap+1 falling edges after the call; answer sampled half a cycle after taking, at the next falling edge
   task automatic access(input logic wr, input logic [11:0] addr, input logic [3:0] be,
                         input spcmd_pkg::spcmd_dword_t wd, input int gap,
                         output logic cpl, output spcmd_pkg::spcmd_dword_t rd);
      repeat (gap + 1) @(negedge core_clk);
      cfg_req_valid = 1'b1;
      cfg_req_write = wr;
      cfg_req_addr = addr;
      cfg_req_be = be;
      cfg_req_wdata = wd;
      @(negedge core_clk);
      cpl = cfg_cpl_valid;
      rd = cfg_cpl_rdata;
      // released lines turn over so a stale value cannot pass
      cfg_req_valid = 1'b0;
      cfg_req_write = ~wr;
      cfg_req_addr = ~addr;
      cfg_req_be = ~be;
      cfg_req_wdata = ~wd;
   endtask
endmodule // spcmd_root_model

// ---- test/test_spcmd_regs.sv ----
// self-checking bench of the port id and command registers
`timescale 1ns/1ns
`include "spcmd_cfg.svh"
module test_spcmd_regs;
   // =====================================================
   // signals
   logic core_clk = 1'b0;
   logic srst = 1'b1;
   int err_count = 0;
   int cmp_count = 0;
   int cyc = 0;
   logic [31:0] seed = 32'h0000002D;
   logic [15:0] cmd_m, maker_m, part_m;
   logic maker_load_valid = 1'b0, part_load_valid = 1'b0;
   spcmd_pkg::spcmd_half_t maker_load_data = 16'h0000, part_load_data = 16'h0000;
   logic pri_req_valid = 1'b0, pri_req_io = 1'b0, pri_req_mem = 1'b0;
   logic dsr_req_valid = 1'b0, dsr_req_memio = 1'b0, dsr_req_np = 1'b0;
   logic parity_err_det = 1'b0, err_fatal_det = 1'b0, err_nonfatal_det = 1'b0;
   logic own_intx_req = 1'b0, fwd_intx_req = 1'b0;
   logic cfg_req_valid, cfg_req_write, cfg_cpl_valid;
   logic [11:0] cfg_req_addr;
   logic [3:0] cfg_req_be;
   spcmd_pkg::spcmd_dword_t cfg_req_wdata, cfg_cpl_rdata;
   logic pri_req_take, pri_req_ignore, up_fwd, ur_cpl, parity_handle;
   logic err_fatal_msg, err_nonfatal_msg, intx_own_msg, intx_fwd_msg;
   spcmd_pkg::spcmd_half_t cmd_view;

   always #10 core_clk = ~core_clk;

   spcmd_regs i_dut (.core_clk(core_clk), .srst(srst), .cfg_req_valid(cfg_req_valid),
      .cfg_req_write(cfg_req_write), .cfg_req_addr(cfg_req_addr), .cfg_req_be(cfg_req_be),
      .cfg_req_wdata(cfg_req_wdata), .cfg_cpl_valid(cfg_cpl_valid),
      .cfg_cpl_rdata(cfg_cpl_rdata), .maker_load_valid(maker_load_valid),
      .maker_load_data(maker_load_data), .part_load_valid(part_load_valid),
      .part_load_data(part_load_data), .pri_req_valid(pri_req_valid),
      .pri_req_io(pri_req_io), .pri_req_mem(pri_req_mem), .pri_req_take(pri_req_take),
      .pri_req_ignore(pri_req_ignore), .dsr_req_valid(dsr_req_valid),
      .dsr_req_memio(dsr_req_memio), .dsr_req_np(dsr_req_np), .up_fwd(up_fwd),
      .ur_cpl(ur_cpl), .parity_err_det(parity_err_det), .err_fatal_det(err_fatal_det),
      .err_nonfatal_det(err_nonfatal_det), .parity_handle(parity_handle),
      .err_fatal_msg(err_fatal_msg), .err_nonfatal_msg(err_nonfatal_msg),
      .own_intx_req(own_intx_req), .fwd_intx_req(fwd_intx_req),
      .intx_own_msg(intx_own_msg), .intx_fwd_msg(intx_fwd_msg), .cmd_view(cmd_view));

   spcmd_root_model i_root (.core_clk(core_clk), .cfg_req_valid(cfg_req_valid),
      .cfg_req_write(cfg_req_write), .cfg_req_addr(cfg_req_addr), .cfg_req_be(cfg_req_be),
      .cfg_req_wdata(cfg_req_wdata), .cfg_cpl_valid(cfg_cpl_valid),
      .cfg_cpl_rdata(cfg_cpl_rdata));

   // =====================================================
   // helpers
   function logic [31:0] rnd();
      seed = seed ^ (seed << 13);
      seed = seed ^ (seed >> 17);
      seed = seed ^ (seed << 5);
      return seed;
   endfunction

   task automatic finish_test;
      if (err_count == 0 && cmp_count > 0) begin
         $display("NO MISMATCHES");
      end else begin
         $display("MISMATCHES SEEN");
      end
      $finish;
   endtask

   task automatic check(input logic [31:0] seen, input logic [31:0] exp);
      cmp_count++;
      if (seen !== exp) begin
         err_count++;
         $display("[FAIL] %0t seen %h expected %h", $time, seen, exp);
      end
   endtask

   task automatic cfg(input logic wr, input logic [11:0] a, input logic [3:0] be,
                      input logic [31:0] wd, output logic [31:0] rd);
      logic cpl;
      int gap;
      gap = int'(rnd() % 32'd3);
      i_root.access(wr, a, be, wd, gap, cpl, rd);
      check({31'h0, cpl}, 32'h1);
   endtask

   task automatic read_all;
      logic [31:0] rd;
      cfg(1'b0, 12'h000, 4'hF, 32'h0, rd);
      check(rd, {part_m, maker_m});
      cfg(1'b0, 12'h006, 4'hF, 32'h0, rd);
      check(rd, {16'h0000, cmd_m});
      check(cmd_view, cmd_m);
   endtask

   // writable command bits are 0,1,2,6,8,10 only
   task automatic cmd_write(input logic [31:0] wd, input logic [3:0] be);
      logic [31:0] rd;
      logic [15:0] lane;
      lane = {{8{be[1]}}, {8{be[0]}}} & 16'h0547;
      cfg(1'b1, 12'h004, be, wd, rd);
      check(rd, 32'h0);
      cmd_m = (cmd_m & ~lane) | (wd[15:0] & lane);
   endtask

   // called at a falling edge; outputs follow one cycle later
   task automatic gate_check(input logic [31:0] r);
      {fwd_intx_req, own_intx_req, err_nonfatal_det, err_fatal_det} = r[10:7];
      {parity_err_det, dsr_req_np, dsr_req_memio, dsr_req_valid} = r[6:3];
      {pri_req_mem, pri_req_io, pri_req_valid} = r[2:0];
      @(negedge core_clk);
      check(pri_req_take, r[0] & ((r[1] & cmd_m[0]) | (r[2] & cmd_m[1])));
      check(pri_req_ignore, r[0] & ~((r[1] & cmd_m[0]) | (r[2] & cmd_m[1])));
      check(up_fwd, r[3] & r[4] & cmd_m[2]);
      check(ur_cpl, r[3] & r[4] & r[5] & ~cmd_m[2]);
      check(parity_handle, r[6] & cmd_m[6]);
      check({err_fatal_msg, err_nonfatal_msg}, {r[7], r[8]} & {2{cmd_m[8]}});
      check({intx_own_msg, intx_fwd_msg}, {r[9] & ~cmd_m[10], r[10]});
   endtask

   task automatic reset_all;
      srst = 1'b1;
      repeat (10) @(negedge core_clk);
      srst = 1'b0;
      cmd_m = 16'h0000;
      maker_m = `SPCMD_MAKER_PRESET;
      part_m = `SPCMD_PART_PRESET;
   endtask

   // =====================================================
   // main sequence
   always @(posedge core_clk) begin
      cyc <= cyc + 1;
      if (cyc == 8000) begin
         err_count++;
         finish_test;
      end
   end

   initial begin
      logic [31:0] rd;
      logic [31:0] r;
      logic cpl;
      reset_all;
      read_all;
      // id writes dropped, unmapped dword reads zero
      cfg(1'b1, 12'h000, 4'hF, rnd(), rd);
      cfg(1'b1, 12'h010, 4'hF, rnd(), rd);
      cfg(1'b0, 12'h010, 4'hF, 32'h0, rd);
      check(rd, 32'h0);
      read_all;
      // id loads, read taken at the very next edge must see the new codes
      r = rnd();
      @(negedge core_clk);
      {part_load_data, maker_load_data} = r;
      {part_load_valid, maker_load_valid} = 2'b11;
      {part_m, maker_m} = r;
      fork
         begin
            @(negedge core_clk);
            {part_load_valid, maker_load_valid} = 2'b00;
            {part_load_data, maker_load_data} = ~r;
         end
         i_root.access(1'b0, 12'h000, 4'hF, 32'h0, 0, cpl, rd);
      join
      check({31'h0, cpl}, 32'h1);
      check(rd, r);
      read_all;
      cmd_write(32'hFFFFFFFF, 4'hF);
      read_all;
      for (int i = 0; i < 40; i++) begin
         r = rnd();
         cmd_write(rnd(), r[3:0]);
         read_all;
         repeat (4) gate_check(rnd());
      end
      cmd_write(32'h00000000, 4'hF);
      repeat (8) gate_check(rnd());
      cmd_write(32'hFFFFFFFF, 4'h3);
      reset_all;
      read_all;
      finish_test;
   end
endmodule // test_spcmd_regs
